// file: pkg/filt_pkg.sv
/*
  Shared constants for the modulator decimation filter and its sample FIFO.
  Assumes the filter runs on the main clock with a modulator tick at half rate.
*/
package filt_pkg;
  // Widths and depths
  localparam int SAMPLE_W    = 16;
  localparam int ACC_W       = 32;
  localparam int WIDE_W      = 40;
  localparam int PHASE_W     = 14;
  localparam int SETTLE_W    = 16;
  localparam int FIFO_DEPTH  = 8;

  // Ratio decoding: overall ratio is 2^(BASE_LOG + select)
  localparam logic [5:0] BASE_LOG    = 6'h07;
  localparam logic [5:0] SINC3_LOG   = 6'h0A;
  localparam logic [5:0] OUT_LOG     = 6'h0F;
  localparam logic [2:0] SINC1_FROM  = 3'h4;

  // Start-up wait after reset, in modulator periods
  localparam logic [9:0] START_WAIT_A = 10'h100;
  localparam logic [9:0] START_WAIT_B = 10'h02C;

  // Conversions served by the fast-settling path
  localparam logic [1:0] FAST_CONVERSIONS = 2'h2;

  // Data-ready low time, in modulator periods
  localparam logic [3:0] READY_LOW_MOD = 4'h8;

  // Settling times in modulator periods, per ratio
  localparam logic [SETTLE_W-1:0] SETTLE_128   = 16'h01B0;
  localparam logic [SETTLE_W-1:0] SETTLE_256   = 16'h0330;
  localparam logic [SETTLE_W-1:0] SETTLE_512   = 16'h0630;
  localparam logic [SETTLE_W-1:0] SETTLE_1024  = 16'h0C30;
  localparam logic [SETTLE_W-1:0] SETTLE_2048  = 16'h1830;
  localparam logic [SETTLE_W-1:0] SETTLE_4096  = 16'h2830;
  localparam logic [SETTLE_W-1:0] SETTLE_8192  = 16'h4830;
  localparam logic [SETTLE_W-1:0] SETTLE_16384 = 16'h8830;
endpackage

// file: pkg/sample_stream_if.sv
/*
  Valid/ready carrier for filter samples between the filter and its FIFO.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps
interface sample_stream_if #(parameter int WIDTH = 16);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// file: hw/sample_fifo.sv
/*
  Synchronous FIFO of parameterised width and depth with valid/ready on both sides.
  Assumes DEPTH is a power of two and one clock for both sides.
*/
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst_n,
  // Filling side
  sample_stream_if.snk        fill,
  // Draining side
  sample_stream_if.src        drain
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [PTR_W:0]   count_reg;
  logic             doPush;
  logic             doPop;

  assign fill.ready  = (count_reg != (PTR_W+1)'(DEPTH));
  assign drain.valid = (count_reg != '0);
  assign drain.data  = mem[rdPtr_reg];
  assign doPush      = fill.valid && fill.ready;
  assign doPop       = drain.valid && drain.ready;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= fill.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (doPush && !doPop) begin
        count_reg <= count_reg + 1'b1;
      end else if (doPop && !doPush) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sample_fifo

// file: hw/sigma_delta_decimation_filter.sv
/*
  Decimation filter behind a one-bit delta-sigma modulator: fast-settling sinc1
  path for the first conversions, sinc3 (plus sinc1 for high ratios) afterwards,
  settling tracking, data-ready strobe and an 8-word output FIFO.
  Assumes modBit is asynchronous to clk; all other inputs come from clk logic.
*/
`timescale 1ns/100ps
// Behaviour
// R1: Modulator bit feeds sinc3 path and fast-settling path in parallel.
// R2: First conversions after reset come from the fast first-order averager.
// R3: After two fast conversions switch to sinc3 path until next reset.
// R4: Ratios 128 to 1024 use the sinc3 stage alone.
// R5: Ratios 2048 and up: sinc3 at 1024, then sinc1 averaging 2 to 16.
// R6: Sinc3 stage is the cube of a length-N moving average.
// R7: Response nulls at multiples of output rate, repeating at modulator rate.
// R8: Settling restarts on enable, mux or gain change, or resync.
// R9: Settling 432, 816, 1584, 3120 periods for ratios 128 to 1024.
// R10: Settling 6192, 10288, 18480, 34864 periods for ratios 2048 to 16384.
// R11: Unsettled results are still issued with their data-ready strobe.
// R12: Host discards results until first data-ready fall after settling.
// R13: Three-bit select picks ratio 128 to 16384; output rate is mod rate over ratio.
// R14: Modulator tick runs at exactly half the main clock.
// R15: After reset wait 256 plus 44 modulator periods before filtering.
// R16: Each result is announced by one data-ready falling edge per period.
// R17: Sinc3 built from three integrators and three combs, no overflow.
// R18: Every result is scaled to a 16-bit two's-complement sample.
module sigma_delta_decimation_filter #(
  parameter logic [15:0] SETTLE_1024  = filt_pkg::SETTLE_1024,
  parameter logic [15:0] SETTLE_2048  = filt_pkg::SETTLE_2048,
  parameter logic [15:0] SETTLE_4096  = filt_pkg::SETTLE_4096,
  parameter logic [15:0] SETTLE_8192  = filt_pkg::SETTLE_8192,
  parameter logic [15:0] SETTLE_16384 = filt_pkg::SETTLE_16384
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Modulator stream
  input  wire logic        modBit,
  // Configuration
  input  wire logic [2:0]  ratioSelect,
  input  wire logic        channelEnable,
  input  wire logic        configChange,
  input  wire logic        resyncPulse,
  // Sample reader
  input  wire logic        sampleTake,
  output logic      [15:0] sampleData,
  output logic             sampleValid,
  output logic             sampleReadyN,
  // Status
  output logic             settled,
  output logic             fastActive,
  output logic             overrun
);
  localparam int AW = filt_pkg::ACC_W;
  localparam int WW = filt_pkg::WIDE_W;

  // Scale a value of full scale 2^pow to a saturated 16-bit sample
  function automatic logic [15:0] scaleSample(input logic signed [WW-1:0] v, input logic [5:0] pow);
    logic signed [WW+15:0] w;
    w = {{16{v[WW-1]}}, v};
    if (pow >= filt_pkg::OUT_LOG) begin
      w = w >>> (pow - filt_pkg::OUT_LOG);
    end else begin
      w = w <<< (filt_pkg::OUT_LOG - pow);
    end
    if (w > (WW+16)'(32767)) begin
      scaleSample = 16'h7FFF;
    end else if (w < -(WW+16)'(32768)) begin
      scaleSample = 16'h8000;
    end else begin
      scaleSample = w[15:0];
    end
  endfunction

  function automatic logic [15:0] settleTime(input logic [2:0] sel);
    case (sel)
      3'h0:    settleTime = filt_pkg::SETTLE_128;
      3'h1:    settleTime = filt_pkg::SETTLE_256;
      3'h2:    settleTime = filt_pkg::SETTLE_512;
      3'h3:    settleTime = SETTLE_1024;
      3'h4:    settleTime = SETTLE_2048;
      3'h5:    settleTime = SETTLE_4096;
      3'h6:    settleTime = SETTLE_8192;
      default: settleTime = SETTLE_16384;
    endcase
  endfunction

  logic                 modSync1_reg;
  logic                 modSync2_reg;
  logic                 modTick_reg;
  logic [9:0]           waitCnt_reg;
  logic                 running_reg;
  logic [2:0]           ratioPrev_reg;
  logic                 enablePrev_reg;
  logic [filt_pkg::PHASE_W-1:0] phase_reg;
  logic signed [AW-1:0] integ_reg [3];
  logic signed [AW-1:0] combDly_reg [3];
  logic signed [AW-1:0] combVal [4];
  logic signed [WW-1:0] sinc1Acc_reg;
  logic [3:0]           sinc1Cnt_reg;
  logic signed [WW-1:0] fastAcc_reg;
  logic [1:0]           convCnt_reg;
  logic [15:0]          settleCnt_reg;
  logic [3:0]           lowCnt_reg;
  logic [15:0]          pushData_reg;
  logic                 pushValid_reg;
  logic [15:0]          sampleData_reg;
  logic                 sampleValid_reg;
  logic                 sampleReadyN_reg;
  logic                 settled_reg;
  logic                 overrun_reg;
  logic                 fastActive_reg;

  logic                 step;
  logic                 restart;
  logic signed [AW-1:0] bitVal;
  logic [13:0]          ratioMask;
  logic [9:0]           sinc3Mask;
  logic                 decimTick;
  logic                 resultTick;
  logic                 sinc1Mode;
  logic [5:0]           ratioLog;
  logic [5:0]           sinc3Log;
  logic [3:0]           sinc1Mask;
  logic signed [WW-1:0] sinc3Wide;
  logic signed [WW-1:0] sinc1Sum;
  logic signed [WW-1:0] fastSum;
  logic [15:0]          result;

  sample_stream_if #(.WIDTH(filt_pkg::SAMPLE_W)) fillLink ();
  sample_stream_if #(.WIDTH(filt_pkg::SAMPLE_W)) drainLink ();

  // Ratio decoding
  assign ratioLog   = filt_pkg::BASE_LOG + {3'h0, ratioSelect};                      // [R13]
  assign sinc1Mode  = (ratioSelect >= filt_pkg::SINC1_FROM);                         // [R4] [R5]
  assign sinc3Log   = sinc1Mode ? filt_pkg::SINC3_LOG : ratioLog;                    // [R5]
  assign ratioMask  = 14'h3FFF >> (3'h7 - ratioSelect);
  assign sinc3Mask  = sinc1Mode ? 10'h3FF : (10'h3FF >> (3'h3 - ratioSelect[1:0]));
  assign sinc1Mask  = sinc1Mode ? (4'hF >> (3'h7 - ratioSelect)) : 4'h0;

  assign step       = modTick_reg && running_reg && channelEnable;                   // [R14]
  assign restart    = configChange || resyncPulse || (ratioSelect != ratioPrev_reg)
                      || (channelEnable && !enablePrev_reg);                         // [R8]
  assign bitVal     = modSync2_reg ? AW'(1) : -AW'(1);
  assign decimTick  = step && ((phase_reg[9:0] & sinc3Mask) == sinc3Mask);
  assign resultTick = step && (phase_reg == ratioMask);                              // [R13] [R16]

  // Combs at the decimated rate, unit differential delay
  always_comb begin
    combVal[0] = integ_reg[2];
    for (int k = 0; k < 3; k++) begin
      combVal[k+1] = combVal[k] - combDly_reg[k];                                     // [R17] [R6] [R7]
    end
  end

  assign sinc3Wide = WW'(combVal[3]);
  assign sinc1Sum  = sinc1Acc_reg + sinc3Wide;                                       // [R5]
  assign fastSum   = fastAcc_reg + WW'(bitVal);                                      // [R2]

  // Path choice and scaling to the common 16-bit range
  always_comb begin
    if (convCnt_reg < filt_pkg::FAST_CONVERSIONS) begin
      result = scaleSample(fastSum, ratioLog);                                       // [R2] [R18]
    end else if (sinc1Mode) begin
      // Full scale is 2^(30 + sinc1 log) = 2^(ratioLog + 20)
      result = scaleSample(sinc1Sum, ratioLog + filt_pkg::SINC3_LOG + filt_pkg::SINC3_LOG); // [R5] [R18]
    end else begin
      result = scaleSample(sinc3Wide, 6'(3 * sinc3Log));                             // [R4] [R18]
    end
  end

  // Input synchroniser and modulator tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modSync1_reg <= 1'b0;
      modSync2_reg <= 1'b0;
      modTick_reg  <= 1'b0;
    end else begin
      modSync1_reg <= modBit;
      modSync2_reg <= modSync1_reg;
      modTick_reg  <= !modTick_reg;                                                  // [R14]
    end
  end

  // Start-up wait and change detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt_reg    <= '0;
      running_reg    <= 1'b0;
      ratioPrev_reg  <= 3'h0;
      enablePrev_reg <= 1'b0;
    end else begin
      ratioPrev_reg  <= ratioSelect;
      enablePrev_reg <= channelEnable;
      if (modTick_reg && !running_reg) begin
        if (waitCnt_reg == filt_pkg::START_WAIT_A + filt_pkg::START_WAIT_B - 10'h001) begin
          running_reg <= 1'b1;                                                       // [R15]
        end else begin
          waitCnt_reg <= waitCnt_reg + 10'h001;                                      // [R15]
        end
      end
    end
  end

  // Filter datapath
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg    <= '0;
      sinc1Acc_reg <= '0;
      sinc1Cnt_reg <= '0;
      fastAcc_reg  <= '0;
      for (int k = 0; k < 3; k++) begin
        integ_reg[k]   <= '0;
        combDly_reg[k] <= '0;
      end
    end else if (restart || !channelEnable) begin
      phase_reg    <= '0;                                                            // [R8]
      sinc1Acc_reg <= '0;
      sinc1Cnt_reg <= '0;
      fastAcc_reg  <= '0;
      for (int k = 0; k < 3; k++) begin
        integ_reg[k]   <= '0;
        combDly_reg[k] <= '0;
      end
    end else if (step) begin
      phase_reg    <= resultTick ? '0 : phase_reg + 1'b1;
      integ_reg[0] <= integ_reg[0] + bitVal;                                         // [R1] [R17]
      integ_reg[1] <= integ_reg[1] + integ_reg[0];                                   // [R17]
      integ_reg[2] <= integ_reg[2] + integ_reg[1];                                   // [R17]
      fastAcc_reg  <= resultTick ? '0 : fastSum;                                     // [R1] [R2]
      if (decimTick) begin
        for (int k = 0; k < 3; k++) begin
          combDly_reg[k] <= combVal[k];                                              // [R17]
        end
        if (sinc1Mode) begin
          sinc1Acc_reg <= (sinc1Cnt_reg == sinc1Mask) ? '0 : sinc1Sum;               // [R5]
          sinc1Cnt_reg <= (sinc1Cnt_reg == sinc1Mask) ? 4'h0 : sinc1Cnt_reg + 4'h1;
        end
      end
    end
  end

  // Path selection, lasts until reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      convCnt_reg    <= 2'h0;
      fastActive_reg <= 1'b1;
    end else if (resultTick && convCnt_reg < filt_pkg::FAST_CONVERSIONS) begin
      convCnt_reg    <= convCnt_reg + 2'h1;                                          // [R3]
      fastActive_reg <= ((convCnt_reg + 2'h1) < filt_pkg::FAST_CONVERSIONS);        // [R2] [R3]
    end
  end

  // Settling tracker
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settleCnt_reg <= '0;
      settled_reg   <= 1'b0;
    end else if (restart || !channelEnable) begin
      settleCnt_reg <= '0;                                                           // [R8]
      settled_reg   <= 1'b0;
    end else if (step && !settled_reg) begin
      if (settleCnt_reg == settleTime(ratioSelect) - 16'h0001) begin
        settled_reg <= 1'b1;                                                         // [R9] [R10]
      end else begin
        settleCnt_reg <= settleCnt_reg + 16'h0001;
      end
    end
  end

  // Result capture and data-ready strobe, never gated by settling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pushData_reg     <= '0;
      pushValid_reg    <= 1'b0;
      sampleReadyN_reg <= 1'b1;
      lowCnt_reg       <= '0;
      overrun_reg      <= 1'b0;
    end else begin
      pushValid_reg <= resultTick;                                                   // [R11]
      if (resultTick) begin
        pushData_reg     <= result;
        sampleReadyN_reg <= 1'b0;                                                    // [R16] [R11]
        lowCnt_reg       <= filt_pkg::READY_LOW_MOD - 4'h1;
      end else if (modTick_reg && !sampleReadyN_reg) begin
        if (lowCnt_reg == 4'h0) begin
          sampleReadyN_reg <= 1'b1;
        end else begin
          lowCnt_reg <= lowCnt_reg - 4'h1;
        end
      end
      if (pushValid_reg && !fillLink.ready) begin
        overrun_reg <= 1'b1;
      end
    end
  end

  assign fillLink.data  = pushData_reg;
  assign fillLink.valid = pushValid_reg;

  sample_fifo #(
    .WIDTH (filt_pkg::SAMPLE_W),
    .DEPTH (filt_pkg::FIFO_DEPTH)
  ) outFifo (
    .clk   (clk),
    .rst_n (rst_n),
    .fill  (fillLink.snk),
    .drain (drainLink.src)
  );

  // Registered output stage
  assign drainLink.ready = !sampleValid_reg || sampleTake;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sampleData_reg  <= '0;
      sampleValid_reg <= 1'b0;
    end else if (drainLink.ready) begin
      sampleValid_reg <= drainLink.valid;
      if (drainLink.valid) begin
        sampleData_reg <= drainLink.data;
      end
    end
  end

  assign sampleData   = sampleData_reg;
  assign sampleValid  = sampleValid_reg;
  assign sampleReadyN = sampleReadyN_reg;
  assign settled      = settled_reg;
  assign fastActive   = fastActive_reg;
  assign overrun      = overrun_reg;
endmodule // sigma_delta_decimation_filter

// file: verif/sigma_delta_decimation_filter_asserts.sv
/*
  Port checker for the decimation filter, bound to every instance.
  Assumes it sees the filter's top-level ports only.
*/
`timescale 1ns/100ps
module sigma_delta_decimation_filter_asserts #(
  parameter logic [15:0] SETTLE_1024  = filt_pkg::SETTLE_1024,
  parameter logic [15:0] SETTLE_2048  = filt_pkg::SETTLE_2048,
  parameter logic [15:0] SETTLE_4096  = filt_pkg::SETTLE_4096,
  parameter logic [15:0] SETTLE_8192  = filt_pkg::SETTLE_8192,
  parameter logic [15:0] SETTLE_16384 = filt_pkg::SETTLE_16384
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Stream and configuration
  input wire logic        modBit,
  input wire logic [2:0]  ratioSelect,
  input wire logic        channelEnable,
  input wire logic        configChange,
  input wire logic        resyncPulse,
  // Reader and status
  input wire logic        sampleTake,
  input wire logic [15:0] sampleData,
  input wire logic        sampleValid,
  input wire logic        sampleReadyN,
  input wire logic        settled,
  input wire logic        fastActive,
  input wire logic        overrun
);
  logic [2:0]  ratioReg;
  logic [16:0] gapCnt;
  logic        cleanReg;
  logic [1:0]  dropCnt;
  logic        restart;

  assign restart = configChange | resyncPulse | ~channelEnable | (ratioSelect != ratioReg);

  // Spacing of results, trusted only with no restart in between
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ratioReg <= 3'h0;
      gapCnt   <= 17'h00000;
      cleanReg <= 1'b0;
      dropCnt  <= 2'h0;
    end else begin
      ratioReg <= ratioSelect;
      cleanReg <= ~restart & (cleanReg | $fell(sampleReadyN));
      if ($fell(sampleReadyN)) begin
        gapCnt  <= 17'h00001;
        dropCnt <= (dropCnt == 2'h3) ? 2'h3 : dropCnt + 2'h1;
      end else if (gapCnt != 17'h1FFFF) begin
        gapCnt <= gapCnt + 17'h00001;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_low_width;
    $fell(sampleReadyN) |-> ##15 !sampleReadyN ##1 sampleReadyN;
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("data-ready low time wrong");

  property p_period;
    $fell(sampleReadyN) && cleanReg |-> gapCnt == (17'h00100 << ratioSelect);
  endproperty
  a_period: assert property (p_period)
    else $error("result spacing wrong");

  property p_hold;
    sampleValid && !sampleTake |=> sampleValid && $stable(sampleData);
  endproperty
  a_hold: assert property (p_hold)
    else $error("sample dropped before taken");

  property p_overrun;
    overrun |=> overrun;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun flag cleared");

  property p_quiet;
    !channelEnable && !$past(channelEnable) |-> !$fell(sampleReadyN);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("result while channel disabled");

  property p_unsettle;
    configChange || resyncPulse |=> !settled;
  endproperty
  a_unsettle: assert property (p_unsettle)
    else $error("settled kept after restart");

  property p_fast_off;
    dropCnt[1] |-> !fastActive;
  endproperty
  a_fast_off: assert property (p_fast_off)
    else $error("fast path beyond two results");

  property p_fast_on;
    !dropCnt[1] && sampleReadyN |-> fastActive;
  endproperty
  a_fast_on: assert property (p_fast_on)
    else $error("fast path left before two results");

  property p_fast_stay;
    !fastActive |=> !fastActive;
  endproperty
  a_fast_stay: assert property (p_fast_stay)
    else $error("fast path re-entered");
endmodule // sigma_delta_decimation_filter_asserts

bind sigma_delta_decimation_filter sigma_delta_decimation_filter_asserts #(
  .SETTLE_1024(SETTLE_1024), .SETTLE_2048(SETTLE_2048), .SETTLE_4096(SETTLE_4096),
  .SETTLE_8192(SETTLE_8192), .SETTLE_16384(SETTLE_16384)
) checker_i (
  .clk(clk), .rst_n(rst_n), .modBit(modBit), .ratioSelect(ratioSelect),
  .channelEnable(channelEnable), .configChange(configChange), .resyncPulse(resyncPulse),
  .sampleTake(sampleTake), .sampleData(sampleData), .sampleValid(sampleValid),
  .sampleReadyN(sampleReadyN), .settled(settled), .fastActive(fastActive), .overrun(overrun)
);

// file: verif/mod_stream_model.sv
/*
  Modulator bit source in front of the filter.
  Assumes the bench changes mode between tests only.
*/
`timescale 1ns/100ps
module mod_stream_model (
  // Clock and control
  input  wire logic       clk,
  input  wire logic [1:0] mode,
  // Modulator stream
  output logic            modBit
);
  logic [1:0] phaseReg = 2'h0;

  // Mode 0 steady -1, 1 steady +1, else +1/-1 at half the modulator rate
  always_ff @(posedge clk) begin
    phaseReg <= phaseReg + 2'h1;
    case (mode)
      2'h0:    modBit <= 1'b0;
      2'h1:    modBit <= 1'b1;
      default: modBit <= phaseReg[1];
    endcase
  end
endmodule // mod_stream_model

// file: verif/tb.sv
/*
  Self-checking bench for the decimation filter.
  Assumes the filter, its FIFO, the bit source and the bound checker.
*/
`timescale 1ns/100ps
module tb;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [1:0]  mode = 2'h1;
  logic        modBit;
  logic [2:0]  ratioSelect = 3'h0;
  logic        channelEnable = 1'b1;
  logic        configChange = 1'b0;
  logic        resyncPulse = 1'b0;
  logic        sampleTake = 1'b1;
  logic [15:0] sampleData;
  logic        sampleValid;
  logic        sampleReadyN;
  logic        settled;
  logic        fastActive;
  logic        overrun;
  int          errorCnt = 0;
  int          checks = 0;
  int          cycles = 0;
  logic [15:0] rxQ[$];

  always #2 clk = ~clk;

  mod_stream_model partner (.clk(clk), .mode(mode), .modBit(modBit));

  sigma_delta_decimation_filter #(
    .SETTLE_1024(16'h0040), .SETTLE_2048(16'h0040), .SETTLE_4096(16'h0040),
    .SETTLE_8192(16'h0040), .SETTLE_16384(16'h0040)
  ) DUT (
    .clk(clk), .rst_n(rst_n), .modBit(modBit), .ratioSelect(ratioSelect),
    .channelEnable(channelEnable), .configChange(configChange), .resyncPulse(resyncPulse),
    .sampleTake(sampleTake), .sampleData(sampleData), .sampleValid(sampleValid),
    .sampleReadyN(sampleReadyN), .settled(settled), .fastActive(fastActive), .overrun(overrun)
  );

  // Reader capture and hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (sampleValid === 1'b1 && sampleTake === 1'b1) rxQ.push_back(sampleData);
    if (cycles == 100000) begin
      errorCnt = errorCnt + 1;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("Checks %0d, errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      errorCnt = errorCnt + 1;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // Cycles until the next data-ready fall
  task automatic wait_fall(output int n);
    n = 0;
    while (sampleReadyN !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
    end
    while (sampleReadyN !== 1'b0 && n < 40000) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Cause 0 config pulse, 1 resync pulse, 2 channel disabled for a while
  task automatic restart(input int cause);
    while (sampleReadyN !== 1'b1) @(posedge clk);
    configChange  <= (cause == 0);
    resyncPulse   <= (cause == 1);
    channelEnable <= (cause != 2);
    @(posedge clk);
    configChange <= 1'b0;
    resyncPulse  <= 1'b0;
    if (cause == 2) repeat (600) @(posedge clk);
    channelEnable <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_startup;
    int n;
    wait_fall(n);
    check(17'(n > 850 && n < 866), 17'h1);
    check({16'h0, fastActive}, 17'h1);
    wait_fall(n);
    wait_fall(n);
    repeat (6) @(posedge clk);
    check({16'h0, fastActive}, 17'h0);
    check(17'(rxQ.size()), 17'h3);
    check({1'b0, rxQ[1]}, 17'h07FFF);
  endtask

  task automatic t_settle(input int cause, input logic [1:0] m, input logic [15:0] exp);
    int   n;
    int   res;
    logic prev;
    mode <= m;
    restart(cause);
    n = 0;
    res = 0;
    prev = 1'b1;
    while (settled !== 1'b1 && n < 40000) begin
      @(posedge clk);
      n++;
      if (sampleReadyN === 1'b0 && prev === 1'b1) res++;
      prev = sampleReadyN;
    end
    check(17'(n > 854 && n < 876), 17'h1);
    check(17'(res), 17'h3);
    rxQ.delete();
    wait_fall(n);
    repeat (6) @(posedge clk);
    check({1'b0, rxQ[0]}, {1'b0, exp});
  endtask

  task automatic t_overrun;
    int n;
    sampleTake <= 1'b0;
    repeat (11) wait_fall(n);
    repeat (4) @(posedge clk);
    check({15'h0, overrun, sampleValid}, 17'h3);
    rxQ.delete();
    sampleTake <= 1'b1;
    repeat (20) @(posedge clk);
    check(17'(rxQ.size()), 17'h9);
    foreach (rxQ[i]) check({1'b0, rxQ[i]}, 17'h07FFF);
    check({16'h0, overrun}, 17'h1);
  endtask

  // Ends on ratio 128 so that every step changes the ratio
  task automatic t_ratios;
    int n;
    int s;
    for (int i = 1; i < 9; i++) begin
      s = i & 7;
      while (sampleReadyN !== 1'b1) @(posedge clk);
      ratioSelect <= 3'(s);
      wait_fall(n);
      check(17'(n > (256 << s) - 4 && n < (256 << s) + 8), 17'h1);
      check({16'h0, settled}, 17'(s > 2));
    end
  endtask

  initial begin
    repeat (6) @(posedge clk);
    check({1'b0, sampleData}, 17'h00000);
    check({12'h0, sampleValid, sampleReadyN, settled, fastActive, overrun}, 17'h0000A);
    rst_n <= 1'b1;
    t_startup();
    t_settle(0, 2'h0, 16'h8000);
    t_settle(1, 2'h2, 16'h0000);
    t_settle(2, 2'h1, 16'h7FFF);
    t_overrun();
    t_ratios();
    end_sim();
  end
endmodule // tb
